// ===== common/nvprog_pkg.sv
// Purpose: constants and types for the nonvolatile program control block
// Assumes: register index times four is the APB byte address
// Notes: register field layouts are the packed structs below
package nvprog_pkg;
   // register indices
   localparam logic [5:0] IDX_EPROM_CTL  = 6'h2B;
   localparam logic [5:0] IDX_BLK_PROT   = 6'h35;
   localparam logic [5:0] IDX_OPTIONS    = 6'h39;
   localparam logic [5:0] IDX_EEPROM_CTL = 6'h3B;
   localparam logic [5:0] IDX_MODE       = 6'h3C;
   localparam logic [5:0] IDX_STATUS     = 6'h3D;
   // values after reset
   localparam logic [7:0] CTL_RST        = 8'h00;
   localparam logic [7:0] OPTIONS_RST    = 8'h10;
   localparam logic [7:0] BLK_PROT_RST   = 8'hFF;
   localparam logic [7:0] MODE_RST       = 8'h00;
   localparam int         PUMP_CLOCK_SELECT_POS       = 6;
   // clearing of protect bits is open for this many cycles
   localparam logic [6:0] PROT_WINDOW_CYC = 7'h40;
   // eprom address and data masks for the factory modes
   localparam logic [15:0] MBE_ADDR_MASK  = 16'h0020;
   localparam logic [15:0] EXTRA_COLUMN_SELECT_IGN_MASK = 16'h001E;
   localparam logic [15:0] EXTRA_ROW_SELECT_IGN_MASK = 16'h0FC0;
   localparam logic [7:0]  EXTRA_COLUMN_SELECT_DATA_MASK = 8'h81;
   // eeprom region boundaries, offsets within the 4-K page
   localparam logic [11:0] EE_OFF_R0 = 12'hD80;
   localparam logic [11:0] EE_OFF_R1 = 12'hDA0;
   localparam logic [11:0] EE_OFF_R2 = 12'hDE0;
   localparam logic [11:0] EE_OFF_R3 = 12'hE60;
   localparam logic [11:0] EE_OFF_R4 = 12'hF80;
   // erase scope codes
   localparam logic [1:0] SCOPE_BULK = 2'h0;
   localparam logic [1:0] SCOPE_ROW  = 2'h1;
   localparam logic [1:0] SCOPE_BYTE = 2'h2;

   typedef struct packed {
      logic       multi_byte_program;
      logic       rsv6;
      logic       eprom_latch;
      logic       extra_column_select;
      logic       extra_row_select;
      logic [1:0] rsv_lo;
      logic       eprom_voltage_enable;
   } eprom_ctl_s;

   typedef struct packed {
      logic odd_rows;
      logic even_rows;
      logic low_voltage_inhibit_status;
      logic byte_erase;
      logic row_erase;
      logic erase_mode;
      logic eeprom_latch;
      logic eeprom_voltage_command;
   } eeprom_ctl_s;

   typedef struct packed {
      logic       bulk_erase_protect;
      logic       low_voltage_protect_enable;
      logic       config_protect;
      logic [4:0] region_protect_bits;
   } blk_prot_s;

   typedef struct packed {
      logic [4:0] rsv;
      logic       eeprom_visible_enable;
      logic       bootstrap;
      logic       special_test;
   } mode_s;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_LATCHED = 4'h2,
      ST_ARMED   = 4'h4,
      ST_PROG    = 4'h8
   } ee_state_e;
endpackage : nvprog_pkg

// ===== rtl/nvprog_ctrl.sv
// Purpose: program/erase control for on-chip EPROM and EEPROM arrays
// Assumes: APB slave with one wait state; array strobes on SYS_CLK
// Notes: array-side outputs are registered, one edge after their cause
//
// Overview of operation
// - latch mode captures EPROM writes, blocks reads
// - latch bit frozen while EPROM voltage on, except by an all-zero write
// - EPROM voltage bit writable only when latched
// - multi-byte mode ignores address bit five
// - extra columns: data bits 7,0, address 11:5 and 0
// - extra rows: address bits 5:0 only
// - EEPROM latch clear gives plain reads
// - pump clock select picks E or RC
// - EEPROM voltage needs latch, address, command order
// - latch and command together set neither
// - inhibit status bit always reads zero
// - byte and row bits pick erase scope
// - erase bit selects erase or program
// - command bit switches array voltage
// - protect bits clear only in first 64 cycles
// - protect bits settable anytime; special modes free
// - bulk protect refuses bulk and row erase
// - protect enable bit has no effect
// - five protect bits guard five regions
// - array visible only when enabled, writable only when unprotected
// - array writes ignored while command bit set
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module nvprog_ctrl
   import nvprog_pkg::*;
(
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // cpu writes toward the arrays
   input  wire logic        MEM_WR,
   input  wire logic        MEM_EPROM_SEL,
   input  wire logic        MEM_EEPROM_SEL,
   input  wire logic        MEM_CONFIG_SEL,
   input  wire logic [15:0] MEM_ADDR,
   input  wire logic [7:0]  MEM_WDATA,
   // eprom array side
   output logic      [15:0] EP_LATCH_ADDR,
   output logic      [7:0]  EP_LATCH_DATA,
   output logic             EP_VPP_ON,
   output logic             EP_READ_EN,
   output logic             EP_USER_ARRAY_EN,
   output logic             EP_EXTRA_COL,
   output logic             EP_EXTRA_ROW,
   output logic             EP_MULTI_BYTE,
   // eeprom array side
   output logic      [11:0] EE_LATCH_ADDR,
   output logic      [7:0]  EE_LATCH_DATA,
   output logic             EE_LATCH_CONFIG,
   output logic             EE_VPP_ON,
   output logic             EE_ERASE_MODE,
   output logic      [1:0]  EE_ERASE_SCOPE,
   output logic             EE_READ_EN,
   output logic             EE_VISIBLE,
   // charge pump
   output logic             PUMP_CLK_RC
);
   eprom_ctl_s  ep_q, ep_d, ep_w;
   eeprom_ctl_s ee_q, ee_d, ee_w, ee_rd;
   blk_prot_s   bp_q, bp_d;
   mode_s       md_q, md_d;
   ee_state_e   st_q, st_d;
   logic [7:0]  opt_q, opt_d;
   logic [6:0]  win_q;
   logic        refused_q;
   logic [7:0]  w8, rd_byte, status;
   logic [5:0]  idx;
   logic [11:0] off;
   logic [4:0]  reg_hit;
   logic [15:0] ep_mask;
   logic        hit, acc, wr_en, wr_ep, wr_ee, wr_bp, wr_opt, wr_md;
   logic        win_open, ep_cap, in_array, prot, cfg_ok;
   logic        erase_refused, ee_attempt, ee_ok;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   // apb decode
   assign idx    = PADDR[7:2];
   assign w8     = PWDATA[7:0];
   assign acc    = PSEL & PENABLE;
   assign hit    = (PADDR[1:0] == 2'h0) &&
                   (idx == IDX_EPROM_CTL || idx == IDX_BLK_PROT ||
                    idx == IDX_OPTIONS || idx == IDX_EEPROM_CTL ||
                    idx == IDX_MODE || idx == IDX_STATUS);
   assign wr_en  = acc & PREADY & PWRITE & hit;
   assign wr_ep  = wr_en & (idx == IDX_EPROM_CTL);
   assign wr_ee  = wr_en & (idx == IDX_EEPROM_CTL);
   assign wr_bp  = wr_en & (idx == IDX_BLK_PROT);
   assign wr_opt = wr_en & (idx == IDX_OPTIONS);
   assign wr_md  = wr_en & (idx == IDX_MODE);
   assign ep_w   = w8;
   assign ee_w   = w8;

   // register readback; latch and command bits reflect the sequencer
   always_comb begin
      ee_rd = ee_q;
      ee_rd.low_voltage_inhibit_status = 1'b0;
      ee_rd.eeprom_latch = (st_q != ST_IDLE);
      ee_rd.eeprom_voltage_command = (st_q == ST_PROG);
   end
   assign status  = {2'h0, refused_q, win_open, st_q};
   assign rd_byte = !hit                   ? 8'h00 :
                    idx == IDX_EPROM_CTL   ? ep_q :
                    idx == IDX_BLK_PROT    ? bp_q :
                    idx == IDX_OPTIONS     ? opt_q :
                    idx == IDX_EEPROM_CTL  ? ee_rd :
                    idx == IDX_MODE        ? md_q : status;

   // one wait state keeps PRDATA and PREADY straight from flops
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end else begin
         PREADY  <= acc & !PREADY;
         PSLVERR <= acc & !PREADY & !hit;
         if (acc && !PREADY) begin
            PRDATA <= {24'h000000, rd_byte};
         end
      end
   end

   // eprom control register
   always_comb begin
      ep_d = ep_q;
      if (wr_ep) begin
         if (w8 == CTL_RST) begin
            ep_d = CTL_RST;
         end else begin
            if (!ep_q.eprom_voltage_enable) begin
               ep_d.eprom_latch = ep_w.eprom_latch;
            end
            if (ep_q.eprom_latch) begin
               ep_d.eprom_voltage_enable = ep_w.eprom_voltage_enable;
            end
            // factory bits can only be set in special test mode
            if (md_q.special_test) begin
               ep_d.multi_byte_program  = ep_w.multi_byte_program;
               ep_d.extra_column_select = ep_w.extra_column_select;
               ep_d.extra_row_select    = ep_w.extra_row_select;
            end
         end
      end
   end

   // eprom capture path with factory address folding
   assign ep_cap  = MEM_WR & MEM_EPROM_SEL & ep_q.eprom_latch;
   assign ep_mask = ~((ep_q.multi_byte_program  ? MBE_ADDR_MASK  : 16'h0000)
                    | (ep_q.extra_column_select ? EXTRA_COLUMN_SELECT_IGN_MASK : 16'h0000)
                    | (ep_q.extra_row_select    ? EXTRA_ROW_SELECT_IGN_MASK : 16'h0000));

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ep_q          <= CTL_RST;
         EP_LATCH_ADDR <= 16'h0000;
         EP_LATCH_DATA <= 8'h00;
      end else begin
         ep_q <= ep_d;
         if (ep_cap) begin
            EP_LATCH_ADDR <= MEM_ADDR & ep_mask;
            EP_LATCH_DATA <= ep_q.extra_column_select ?
                             (MEM_WDATA & EXTRA_COLUMN_SELECT_DATA_MASK) : MEM_WDATA;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         EP_VPP_ON        <= 1'b0;
         EP_READ_EN       <= 1'b1;
         EP_USER_ARRAY_EN <= 1'b1;
         EP_EXTRA_COL     <= 1'b0;
         EP_EXTRA_ROW     <= 1'b0;
         EP_MULTI_BYTE    <= 1'b0;
      end else begin
         EP_VPP_ON        <= ep_d.eprom_voltage_enable;
         EP_READ_EN       <= !ep_d.eprom_latch;
         EP_USER_ARRAY_EN <= !(ep_d.extra_column_select |
                               ep_d.extra_row_select);
         EP_EXTRA_COL     <= ep_d.extra_column_select;
         EP_EXTRA_ROW     <= ep_d.extra_row_select;
         EP_MULTI_BYTE    <= ep_d.multi_byte_program;
      end
   end

   // eeprom write qualification
   assign off      = MEM_ADDR[11:0];
   assign reg_hit  = {off >= EE_OFF_R4,
                      off >= EE_OFF_R3 && off < EE_OFF_R4,
                      off >= EE_OFF_R2 && off < EE_OFF_R3,
                      off >= EE_OFF_R1 && off < EE_OFF_R2,
                      off < EE_OFF_R1};
   assign prot     = |(reg_hit & bp_q.region_protect_bits);
   assign in_array = MEM_EEPROM_SEL & md_q.eeprom_visible_enable &
                     (off >= EE_OFF_R0);
   assign cfg_ok   = MEM_CONFIG_SEL & !bp_q.config_protect;
   assign erase_refused = ee_q.erase_mode & !ee_q.byte_erase &
                          bp_q.bulk_erase_protect;
   assign ee_attempt = MEM_WR & (MEM_EEPROM_SEL | MEM_CONFIG_SEL) &
                       (st_q != ST_IDLE);
   assign ee_ok    = ee_attempt & (st_q != ST_PROG) &
                     ((in_array & !prot) | cfg_ok) & !erase_refused;

   // programming sequencer
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (wr_ee && ee_w.eeprom_latch &&
                !ee_w.eeprom_voltage_command) begin
               st_d = ST_LATCHED;
            end
         end
         ST_LATCHED: begin
            if (ee_ok) begin
               st_d = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (wr_ee && ee_w.eeprom_latch &&
                ee_w.eeprom_voltage_command) begin
               st_d = ST_PROG;
            end
         end
         ST_PROG: begin
            if (wr_ee && !ee_w.eeprom_voltage_command) begin
               st_d = ST_LATCHED;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      if (wr_ee && !ee_w.eeprom_latch) begin
         st_d = ST_IDLE;
      end
   end

   always_comb begin
      ee_d = ee_q;
      if (wr_ee) begin
         ee_d.byte_erase = ee_w.byte_erase;
         ee_d.row_erase  = ee_w.row_erase;
         ee_d.erase_mode = ee_w.erase_mode;
         if (md_q.special_test) begin
            ee_d.odd_rows  = ee_w.odd_rows;
            ee_d.even_rows = ee_w.even_rows;
         end
      end
      ee_d.low_voltage_inhibit_status = 1'b0;
      ee_d.eeprom_latch = 1'b0;
      ee_d.eeprom_voltage_command = 1'b0;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         st_q            <= ST_IDLE;
         ee_q            <= CTL_RST;
         refused_q       <= 1'b0;
         EE_LATCH_ADDR   <= 12'h000;
         EE_LATCH_DATA   <= 8'h00;
         EE_LATCH_CONFIG <= 1'b0;
      end else begin
         st_q <= st_d;
         ee_q <= ee_d;
         if (ee_attempt) begin
            refused_q <= !ee_ok;
         end
         if (ee_ok) begin
            EE_LATCH_ADDR   <= off;
            EE_LATCH_DATA   <= MEM_WDATA;
            EE_LATCH_CONFIG <= MEM_CONFIG_SEL;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         EE_VPP_ON      <= 1'b0;
         EE_ERASE_MODE  <= 1'b0;
         EE_ERASE_SCOPE <= SCOPE_BULK;
         EE_READ_EN     <= 1'b0;
         EE_VISIBLE     <= 1'b0;
      end else begin
         EE_VPP_ON      <= (st_d == ST_PROG);
         EE_ERASE_MODE  <= ee_d.erase_mode;
         EE_ERASE_SCOPE <= ee_d.byte_erase ? SCOPE_BYTE :
                           ee_d.row_erase ? SCOPE_ROW : SCOPE_BULK;
         EE_READ_EN     <= (st_d == ST_IDLE) &
                           md_d.eeprom_visible_enable;
         EE_VISIBLE     <= md_d.eeprom_visible_enable;
      end
   end

   // block protect, options and mode
   assign win_open = (win_q != PROT_WINDOW_CYC);

   always_comb begin
      bp_d = bp_q;
      if (wr_bp) begin
         if (md_q.special_test || md_q.bootstrap || win_open) begin
            bp_d = w8;
         end else begin
            bp_d = bp_q | w8;
         end
      end
   end
   assign opt_d = wr_opt ? w8 : opt_q;
   always_comb begin
      md_d = md_q;
      if (wr_md) begin
         md_d     = w8;
         md_d.rsv = 5'h00;
      end
   end

   // trades a free-running counter for a fixed, reset-anchored window
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         win_q       <= 7'h00;
         bp_q        <= BLK_PROT_RST;
         opt_q       <= OPTIONS_RST;
         md_q        <= MODE_RST;
         PUMP_CLK_RC <= OPTIONS_RST[PUMP_CLOCK_SELECT_POS];
      end else begin
         if (win_open) begin
            win_q <= 7'(win_q + 7'h01);
         end
         bp_q        <= bp_d;
         opt_q       <= opt_d;
         md_q        <= md_d;
         PUMP_CLK_RC <= opt_d[PUMP_CLOCK_SELECT_POS];
      end
   end

   // checks
   sequence s_vpp_rise;
      !EE_VPP_ON ##1 EE_VPP_ON;
   endsequence
   sequence s_arm_entry;
      (st_q != ST_ARMED) ##1 (st_q == ST_ARMED);
   endsequence

   chk_latch_blocks_rd: assert property (
      ep_q.eprom_latch |-> !EP_READ_EN)
      else $error("eprom read enabled while latched");
   chk_latch_frozen: assert property (
      (wr_ep && w8 != CTL_RST && ep_q.eprom_voltage_enable)
      |=> $stable(ep_q.eprom_latch))
      else $error("latch bit changed under voltage");
   chk_vpp_needs_latch: assert property (
      $rose(EP_VPP_ON) |-> $past(ep_q.eprom_latch, 2))
      else $error("eprom voltage without latch");
   chk_addr_bit_five: assert property (
      (ep_cap && ep_q.multi_byte_program)
      |=> (EP_LATCH_ADDR & MBE_ADDR_MASK) == 16'h0000)
      else $error("address bit five not ignored");
   chk_extra_columns: assert property (
      (ep_cap && ep_q.extra_column_select)
      |=> (EP_LATCH_ADDR & EXTRA_COLUMN_SELECT_IGN_MASK) == 16'h0000
          && (EP_LATCH_DATA & ~EXTRA_COLUMN_SELECT_DATA_MASK) == 8'h00
          && !EP_USER_ARRAY_EN)
      else $error("extra column folding wrong");
   chk_extra_rows: assert property (
      (ep_cap && ep_q.extra_row_select)
      |=> (EP_LATCH_ADDR & EXTRA_ROW_SELECT_IGN_MASK) == 16'h0000)
      else $error("extra row folding wrong");
   chk_plain_reads: assert property (
      EE_READ_EN == (st_q == ST_IDLE && md_q.eeprom_visible_enable))
      else $error("eeprom read enable mismatch");
   chk_pump_clock: assert property (
      PUMP_CLK_RC == opt_q[PUMP_CLOCK_SELECT_POS])
      else $error("pump clock select mismatch");
   chk_vpp_order: assert property (
      s_vpp_rise |-> $past(st_q) == ST_ARMED)
      else $error("eeprom voltage out of order");
   chk_arm_order: assert property (
      s_arm_entry |-> $past(st_q) == ST_LATCHED)
      else $error("armed without latch step");
   chk_both_refused: assert property (
      (wr_ee && st_q == ST_IDLE && ee_w.eeprom_latch
       && ee_w.eeprom_voltage_command)
      |=> st_q == ST_IDLE ##1 !EE_VPP_ON)
      else $error("latch and command set together");
   chk_protect_window: assert property (
      (!win_open && !md_q.special_test && !md_q.bootstrap)
      |=> ($past(bp_q) & ~bp_q) == 8'h00)
      else $error("protect bit cleared late");
   chk_bulk_refused: assert property (
      (ee_attempt && erase_refused) |=> $stable(st_q) && refused_q)
      else $error("protected bulk or row erase taken");
   chk_prog_ignores: assert property (
      (ee_attempt && st_q == ST_PROG) |=> $stable(EE_LATCH_DATA))
      else $error("array write taken under voltage");
   chk_clear_drops: assert property (
      (wr_ep && w8 == CTL_RST) |=> ##1 (!EP_VPP_ON && EP_READ_EN))
      else $error("clear did not drop eprom voltage");
endmodule : nvprog_ctrl
`default_nettype wire

// ===== verif/nvprog_ctrl_tb.sv
// Purpose: self-checking bench for the nonvolatile program control block
// Assumes: apb answers with one wait state; array outputs lag by one edge
// Notes: random data from a fixed seed, corner cases come from small tables
`timescale 1ns/1ps
`default_nettype none
module nvprog_ctrl_tb
   import nvprog_pkg::*;
;
   localparam logic [7:0]  FCTL   [3] = '{8'hA0, 8'h30, 8'h28};
   localparam logic [15:0] FMASK  [3] = '{MBE_ADDR_MASK, EXTRA_COLUMN_SELECT_IGN_MASK,
                                          EXTRA_ROW_SELECT_IGN_MASK};
   localparam logic [7:0]  FDMASK [3] = '{8'hFF, EXTRA_COLUMN_SELECT_DATA_MASK, 8'hFF};
   localparam logic [7:0]  ECTL   [4] = '{8'h06, 8'h0E, 8'h16, 8'h1E};
   localparam logic [11:0] BASE   [5] = '{EE_OFF_R0, EE_OFF_R1, EE_OFF_R2,
                                          EE_OFF_R3, EE_OFF_R4};
   logic        clk       = 1'b0;
   logic        nrst      = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic [31:0] pwdata    = 32'h00000000;
   logic        mem_wr    = 1'b0;
   logic        ep_sel    = 1'b0;
   logic        ee_sel    = 1'b0;
   logic        cfg_sel   = 1'b0;
   logic [15:0] mem_addr  = 16'h0000;
   logic [7:0]  mem_wdata = 8'h00;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic [15:0] ep_addr;
   logic [7:0]  ep_data, ee_data, rdv;
   logic [11:0] ee_addr;
   logic [1:0]  ee_scope;
   logic        ep_vpp, ep_rd, ep_user, ep_col, ep_row, ep_multi;
   logic        ee_cfg, ee_vpp, ee_erase, ee_rd, ee_vis, pump_rc, erv;
   int          fails      = 0;
   int          n_compared = 0;

   always #25 clk = ~clk;

   nvprog_ctrl i_nvprog_ctrl (
      .SYS_CLK(clk), .NRST(nrst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MEM_WR(mem_wr), .MEM_EPROM_SEL(ep_sel), .MEM_EEPROM_SEL(ee_sel),
      .MEM_CONFIG_SEL(cfg_sel), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
      .EP_LATCH_ADDR(ep_addr), .EP_LATCH_DATA(ep_data), .EP_VPP_ON(ep_vpp),
      .EP_READ_EN(ep_rd), .EP_USER_ARRAY_EN(ep_user),
      .EP_EXTRA_COL(ep_col), .EP_EXTRA_ROW(ep_row),
      .EP_MULTI_BYTE(ep_multi), .EE_LATCH_ADDR(ee_addr),
      .EE_LATCH_DATA(ee_data), .EE_LATCH_CONFIG(ee_cfg),
      .EE_VPP_ON(ee_vpp), .EE_ERASE_MODE(ee_erase),
      .EE_ERASE_SCOPE(ee_scope), .EE_READ_EN(ee_rd), .EE_VISIBLE(ee_vis),
      .PUMP_CLK_RC(pump_rc)
   );

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // byte wins over row; neither set means the whole array
   function automatic logic [1:0] scope_of(input logic [7:0] c);
      return c[4] ? SCOPE_BYTE : (c[3] ? SCOPE_ROW : SCOPE_BULK);
   endfunction : scope_of

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [5:0] idx,
                      input logic [1:0] lo, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, lo};
      pwdata  <= {24'h000000, d};
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         $display("[ERR] %0t no ready", $time);
      end
      rdv = prdata[7:0];
      erv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // the two extra edges let the array-side outputs settle
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      apb(1'b1, idx, 2'h0, d);
      tick(2);
   endtask : wr

   task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 2'h0, 8'h00);
      chk(rdv, exp);
   endtask : rdchk

   task automatic refused(input logic exp);
      apb(1'b0, IDX_STATUS, 2'h0, 8'h00);
      chk(rdv[5], exp);
   endtask : refused

   task automatic memw(input logic [2:0] s, input logic [15:0] a,
                       input logic [7:0] d);
      @(posedge clk);
      mem_wr    <= 1'b1;
      {cfg_sel, ee_sel, ep_sel} <= s;
      mem_addr  <= a;
      mem_wdata <= d;
      @(posedge clk);
      mem_wr    <= 1'b0;
      @(posedge clk);
   endtask : memw

   initial begin
      #2000000;
      fails++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      logic [7:0]  v;
      logic [15:0] a;
      void'($urandom(32'hDACA));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      // protect clears must land inside the short window after reset
      rdchk(IDX_BLK_PROT, BLK_PROT_RST);
      wr(IDX_BLK_PROT, 8'h40);
      rdchk(IDX_BLK_PROT, 8'h40);
      rdchk(IDX_EEPROM_CTL, 8'h00);
      rdchk(IDX_OPTIONS, OPTIONS_RST);
      rdchk(IDX_MODE, MODE_RST);
      rdchk(IDX_EPROM_CTL, CTL_RST);
      chk(pump_rc, 1'b0);
      apb(1'b0, 6'h00, 2'h0, 8'h00);
      chk({erv, rdv}, 9'h100);
      apb(1'b1, IDX_OPTIONS, 2'h1, 8'hFF);
      chk(erv, 1'b1);
      rdchk(IDX_OPTIONS, OPTIONS_RST);
      for (int i = 0; i < 4; i++) begin
         v = (8'($urandom) & 8'hBF) | (8'(i[0]) << PUMP_CLOCK_SELECT_POS);
         wr(IDX_OPTIONS, v);
         rdchk(IDX_OPTIONS, v);
         chk(pump_rc, v[PUMP_CLOCK_SELECT_POS]);
      end
      wr(IDX_EPROM_CTL, 8'h01);
      rdchk(IDX_EPROM_CTL, 8'h00);
      wr(IDX_EPROM_CTL, 8'hB8);
      rdchk(IDX_EPROM_CTL, 8'h20);
      chk(ep_rd, 1'b0);
      a = 16'($urandom);
      v = 8'($urandom);
      memw(3'h1, a, v);
      chk({ep_addr, ep_data}, {a, v});
      wr(IDX_EPROM_CTL, 8'h21);
      chk(ep_vpp, 1'b1);
      wr(IDX_EPROM_CTL, 8'h01);
      rdchk(IDX_EPROM_CTL, 8'h21);
      wr(IDX_EPROM_CTL, 8'h00);
      chk({ep_vpp, ep_rd}, 2'h1);
      wr(IDX_MODE, 8'h01);
      for (int i = 0; i < 3; i++) begin
         a = 16'($urandom) | FMASK[i];
         v = 8'($urandom);
         wr(IDX_EPROM_CTL, FCTL[i]);
         memw(3'h1, a, v);
         chk(ep_addr, a & ~FMASK[i]);
         chk(ep_data, v & FDMASK[i]);
         chk({ep_multi, ep_col, ep_row, ep_user},
             {FCTL[i][7], FCTL[i][4], FCTL[i][3], i == 0});
         wr(IDX_EPROM_CTL, 8'h00);
      end
      wr(IDX_MODE, 8'h04);
      chk({ee_vis, ee_rd}, 2'h3);
      wr(IDX_EEPROM_CTL, 8'hE3);
      rdchk(IDX_EEPROM_CTL, 8'h00);
      wr(IDX_EEPROM_CTL, 8'h02);
      chk(ee_rd, 1'b0);
      wr(IDX_EEPROM_CTL, 8'h03);
      chk(ee_vpp, 1'b0);
      memw(3'h4, 16'h0000, 8'h5A);
      chk(ee_cfg, 1'b1);
      v = 8'($urandom);
      memw(3'h2, 16'h0E70, v);
      chk({ee_addr, ee_data}, {12'hE70, v});
      wr(IDX_EEPROM_CTL, 8'h03);
      chk({ee_vpp, ee_erase}, 2'h2);
      memw(3'h2, 16'h0E80, 8'h00);
      chk(ee_addr, 12'hE70);
      rdchk(IDX_STATUS, 8'h28);
      wr(IDX_EEPROM_CTL, 8'h02);
      chk({ee_vpp, ee_rd}, 2'h0);
      rdchk(IDX_EEPROM_CTL, 8'h02);
      wr(IDX_EEPROM_CTL, 8'h00);
      chk({ee_vpp, ee_rd}, 2'h1);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_EEPROM_CTL, ECTL[i]);
         memw(3'h2, 16'h0E70, 8'($urandom));
         wr(IDX_EEPROM_CTL, ECTL[i] | 8'h01);
         chk({ee_vpp, ee_erase, ee_scope},
             {2'h3, scope_of(ECTL[i])});
         wr(IDX_EEPROM_CTL, 8'h00);
      end
      // window is long closed: writes may only set bits now
      wr(IDX_BLK_PROT, 8'h80);
      rdchk(IDX_BLK_PROT, 8'hC0);
      wr(IDX_BLK_PROT, 8'h00);
      rdchk(IDX_BLK_PROT, 8'hC0);
      for (int i = 0; i < 3; i++) begin
         wr(IDX_EEPROM_CTL, ECTL[i]);
         memw(3'h2, 16'h0E70, 8'h00);
         refused(i < 2);
         wr(IDX_EEPROM_CTL, ECTL[i] | 8'h01);
         chk(ee_vpp, i == 2);
         wr(IDX_EEPROM_CTL, 8'h00);
      end
      wr(IDX_MODE, 8'h05);
      // row half-select bits only stick in special test mode
      wr(IDX_EEPROM_CTL, 8'hC0);
      rdchk(IDX_EEPROM_CTL, 8'hC0);
      for (int i = 0; i < 5; i++) begin
         wr(IDX_BLK_PROT, 8'(1 << i));
         rdchk(IDX_BLK_PROT, 8'(1 << i));
         wr(IDX_EEPROM_CTL, 8'h02);
         memw(3'h2, {4'h0, BASE[i]}, 8'h00);
         refused(1'b1);
         memw(3'h2, {4'h0, BASE[(i + 1) % 5]}, 8'h00);
         refused(1'b0);
         chk(ee_addr, BASE[(i + 1) % 5]);
         wr(IDX_EEPROM_CTL, 8'h00);
      end
      wr(IDX_MODE, 8'h01);
      chk({ee_vis, ee_rd}, 2'h0);
      wr(IDX_EEPROM_CTL, 8'h02);
      memw(3'h2, 16'h0E70, 8'h00);
      refused(1'b1);
      wr(IDX_EEPROM_CTL, 8'h00);
      wr(IDX_MODE, 8'h02);
      wr(IDX_BLK_PROT, 8'h00);
      rdchk(IDX_BLK_PROT, 8'h00);
      close_out();
   end
endmodule : nvprog_ctrl_tb
`default_nettype wire
